// [core/abwc_pkg.sv]
/*
 Constants, types and register map of the area bus and wait control block.
 Assumes a single 10 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
package abwc_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [29:0] ABWC_IDX_BUS_WIDTH = 30'h000000EC;
   localparam logic [29:0] ABWC_IDX_ACCESS_STATE = 30'h000000ED;
   localparam logic [29:0] ABWC_IDX_WAIT_MODE_COUNT = 30'h000000EE;
   localparam logic [29:0] ABWC_IDX_WAIT_ENABLE = 30'h000000EF;

   // Reset values.
   localparam logic [7:0] ABWC_RST_WIDTH_8BIT = 8'hFF;
   localparam logic [7:0] ABWC_RST_WIDTH_16BIT = 8'h00;
   localparam logic [7:0] ABWC_RST_ACCESS_STATE = 8'hFF;
   localparam logic [7:0] ABWC_RST_WAIT_MODE_COUNT = 8'hF3;
   localparam logic [7:0] ABWC_RST_WAIT_ENABLE = 8'hFF;

   // Upper nibble of the wait mode and count register is fixed at one.
   localparam logic [7:0] ABWC_WCR_FIXED_ONES = 8'hF0;
   localparam logic [7:0] ABWC_WCR_WRITABLE = 8'h0F;

   // Field positions in the wait mode and count register.
   localparam int ABWC_WAIT_MODE_SELECT_HI = 3;
   localparam int ABWC_WAIT_MODE_SELECT_LO = 2;
   localparam int ABWC_WAIT_COUNT_HI = 1;
   localparam int ABWC_WAIT_COUNT_LO = 0;

   // Operating modes whose external areas default to a 16-bit bus.
   localparam logic [2:0] ABWC_MODE_2 = 3'h2;
   localparam logic [2:0] ABWC_MODE_4 = 3'h4;
   localparam logic [2:0] ABWC_MODE_7 = 3'h7;

   // Cycles after reset release before the synchronised mode pins are trusted.
   localparam logic [1:0] ABWC_STRAP_SETTLE = 2'h2;

   localparam logic [1:0] ABWC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ABWC_RESP_SLVERR = 2'h2;
   localparam logic [1:0] ABWC_NO_WAITS = 2'h0;

   // Wait behaviour applied to one access.
   typedef enum logic [2:0] {
      ABWC_WM_PROG = 3'h0,
      ABWC_WM_NONE = 3'h1,
      ABWC_WM_PIN1 = 3'h2,
      ABWC_WM_AUTO = 3'h3,
      ABWC_WM_PIN0 = 3'h4
   } abwc_wait_mode_t;

   // Bus cycle shape for one access.
   typedef struct packed {
      logic width8;
      logic threeState;
      abwc_wait_mode_t waitMode;
      logic [1:0] waitStates;
   } abwc_access_t;

endpackage

// [core/abwc_area_bus_wait_control.sv]
/*
 Area bus width, access state and wait-state configuration with an AXI4-Lite
 register slave and a per-access lookup port for the CPU bus cycle generator.
 Assumes the mode pins are static straps and access requests come from logic on clk.
*/
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - A cleared width bit makes its area a 16-bit data bus area.
// - A set width bit makes its area an 8-bit data bus area.
// - Access-state bit clear gives two-state cycles, set gives three-state cycles.
// - Width, access-state and wait-enable bits 7..0 map to areas 7..0.
// - Wait mode 00 programmable, 01 no waits, 10 pin wait 1, 11 auto-wait.
// - Wait count codes 00..11 insert zero to three wait states.
// - Eight read/write wait-enable bits, one per area, all one after reset.
// - Cleared wait-enable bit disables wait control, acting as pin wait mode 0.
module abwc_area_bus_wait_control (
   input wire logic clk, // System clock, 10 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [2:0] modePins, // Operating mode straps, asynchronous.
   input wire logic [31:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [31:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic accReq, // Access lookup request, one cycle.
   input wire logic [2:0] accArea, // Area of the requested access.
   output logic accDone, // Lookup answer valid, one cycle.
   output abwc_pkg::abwc_access_t accResult // Cycle shape for the access.
);
   import abwc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.
   logic [2:0] modeSync1, modeSync2;
   logic [1:0] strapCnt, next_strapCnt;
   logic strapDone, next_strapDone;
   logic [7:0] areaWidthSelect, next_areaWidthSelect;
   logic [7:0] areaThreeStateSelect, next_areaThreeStateSelect;
   logic [3:0] waitModeCount, next_waitModeCount;
   logic [7:0] areaWaitEnable, next_areaWaitEnable;
   logic awHeld, next_awHeld, wHeld, next_wHeld;
   logic [29:0] awIndex, next_awIndex;
   logic [7:0] wByte, next_wByte;
   logic wLane, next_wLane;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic next_accDone;
   abwc_access_t next_accResult;
   logic [7:0] rdByte;
   logic rdHit;
   logic [1:0] waitModeSelect;

   ////////////////////////////////////////////////////////////////////////////
   // Mode straps pass two flip-flops; the second is the only reader of the first.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         modeSync1 <= 3'h0;
         modeSync2 <= 3'h0;
      end else begin
         modeSync1 <= modePins;
         modeSync2 <= modeSync1;
      end
   end

   // Register read decode, shared by the read channel.
   always_comb begin
      rdByte = 8'h00;
      rdHit = 1'b1;
      unique case (s_axi_araddr[31:2])
         ABWC_IDX_BUS_WIDTH: rdByte = areaWidthSelect;
         ABWC_IDX_ACCESS_STATE: rdByte = areaThreeStateSelect;
         ABWC_IDX_WAIT_MODE_COUNT: rdByte = ABWC_WCR_FIXED_ONES | {4'h0, waitModeCount};
         ABWC_IDX_WAIT_ENABLE: rdByte = areaWaitEnable;
         default: rdHit = 1'b0;
      endcase
   end

   assign waitModeSelect = waitModeCount[ABWC_WAIT_MODE_SELECT_HI:ABWC_WAIT_MODE_SELECT_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for straps, registers, bus channels and access lookups.
   // The bus stays closed until the straps are caught, so software can never
   // race the mode-dependent bus width default.
   always_comb begin
      next_strapCnt = strapCnt;
      next_strapDone = strapDone;
      next_areaWidthSelect = areaWidthSelect;
      next_areaThreeStateSelect = areaThreeStateSelect;
      next_waitModeCount = waitModeCount;
      next_areaWaitEnable = areaWaitEnable;
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awIndex = awIndex;
      next_wByte = wByte;
      next_wLane = wLane;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_accDone = accReq;
      next_accResult = accResult;

      // Catch the straps once, after the synchroniser has filled.
      if (!strapDone) begin
         if (strapCnt == ABWC_STRAP_SETTLE) begin
            next_strapDone = 1'b1;
            if (modeSync2 == ABWC_MODE_2 || modeSync2 == ABWC_MODE_4 ||
                modeSync2 == ABWC_MODE_7) begin
               next_areaWidthSelect = ABWC_RST_WIDTH_16BIT;
            end else begin
               next_areaWidthSelect = ABWC_RST_WIDTH_8BIT;
            end
         end else begin
            next_strapCnt = strapCnt + 2'h1;
         end
      end

      // Address and data are taken independently, in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awIndex = s_axi_awaddr[31:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wByte = s_axi_wdata[7:0];
         next_wLane = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end

      // Both halves present: commit the write; only byte lane 0 carries data.
      if (awHeld && wHeld && !s_axi_bvalid) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = ABWC_RESP_OKAY;
         unique case (awIndex)
            ABWC_IDX_BUS_WIDTH: begin
               if (wLane) next_areaWidthSelect = wByte;
            end
            ABWC_IDX_ACCESS_STATE: begin
               if (wLane) next_areaThreeStateSelect = wByte;
            end
            ABWC_IDX_WAIT_MODE_COUNT: begin
               if (wLane) next_waitModeCount = wByte[3:0] & ABWC_WCR_WRITABLE[3:0];
            end
            ABWC_IDX_WAIT_ENABLE: begin
               if (wLane) next_areaWaitEnable = wByte;
            end
            default: next_bresp = ABWC_RESP_SLVERR;
         endcase
      end

      // Read channel: answer one cycle after the address is taken.
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, rdByte};
         next_rresp = rdHit ? ABWC_RESP_OKAY : ABWC_RESP_SLVERR;
      end

      next_awready = next_strapDone && !next_awHeld && !next_bvalid;
      next_wready = next_strapDone && !next_wHeld && !next_bvalid;
      next_arready = next_strapDone && !next_rvalid;

      // Access lookup: area number indexes each per-area bit directly.
      if (accReq) begin
         next_accResult.width8 = areaWidthSelect[accArea];
         next_accResult.threeState = areaThreeStateSelect[accArea];
         next_accResult.waitStates = ABWC_NO_WAITS;
         if (!areaWaitEnable[accArea]) begin
            next_accResult.waitMode = ABWC_WM_PIN0;
         end else begin
            next_accResult.waitMode = abwc_wait_mode_t'({1'b0, waitModeSelect});
            // Two-state cycles have no slot for inserted waits.
            if ({1'b0, waitModeSelect} == ABWC_WM_PROG &&
                areaThreeStateSelect[accArea]) begin
               next_accResult.waitStates =
                  waitModeCount[ABWC_WAIT_COUNT_HI:ABWC_WAIT_COUNT_LO];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registering only; every output comes straight from here.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strapCnt <= 2'h0;
         strapDone <= 1'b0;
         areaWidthSelect <= ABWC_RST_WIDTH_8BIT;
         areaThreeStateSelect <= ABWC_RST_ACCESS_STATE;
         waitModeCount <= ABWC_RST_WAIT_MODE_COUNT[3:0];
         areaWaitEnable <= ABWC_RST_WAIT_ENABLE;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIndex <= 30'h00000000;
         wByte <= 8'h00;
         wLane <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ABWC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= ABWC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         accDone <= 1'b0;
         accResult <= '0;
      end else begin
         strapCnt <= next_strapCnt;
         strapDone <= next_strapDone;
         areaWidthSelect <= next_areaWidthSelect;
         areaThreeStateSelect <= next_areaThreeStateSelect;
         waitModeCount <= next_waitModeCount;
         areaWaitEnable <= next_areaWaitEnable;
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awIndex <= next_awIndex;
         wByte <= next_wByte;
         wLane <= next_wLane;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         accDone <= next_accDone;
         accResult <= next_accResult;
      end
   end

endmodule

`default_nettype wire

// [tb/abwc_area_bus_wait_control_chk.sv]
/*
 Port checker for the area bus and wait control block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module abwc_area_bus_wait_control_chk (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic accReq, // Lookup request.
   input wire logic accDone, // Lookup answer.
   input wire abwc_pkg::abwc_access_t accResult, // Lookup result.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic [31:0] s_axi_rdata, // Read data.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready // Write response ready.
);
   import abwc_pkg::*;
   ////////////////////////////////////////////////////////
   // One clock domain, so clock and reset are stated once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Steps of the register bus handshakes.
   sequence readTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence writeRetired;
      s_axi_bvalid && s_axi_bready;
   endsequence
   ////////////////////////////////////////////////////////
   // A lookup is answered exactly one cycle later and never without a request.
   lookup_answer_a: assert property (accReq |=> accDone) else $error("Lookup unanswered.");
   lookup_quiet_a: assert property (!accReq |=> !accDone) else $error("Stray answer.");
   result_hold_a: assert property (!accReq |=> $stable(accResult))
      else $error("Result moved without a lookup.");
   // Waits are only counted for enabled three-state areas in programmable mode.
   two_state_a: assert property (accDone && !accResult.threeState |->
      accResult.waitStates == ABWC_NO_WAITS) else $error("Waits on a two-state area.");
   not_prog_a: assert property (accDone && accResult.waitMode != ABWC_WM_PROG |->
      accResult.waitStates == ABWC_NO_WAITS) else $error("Waits outside programmable mode.");
   mode_range_a: assert property (accDone |-> accResult.waitMode <= ABWC_WM_PIN0)
      else $error("Wait mode out of range.");
   // Registers are eight bits wide, and write responses retire on their handshake.
   read_answer_a: assert property (readTaken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("Bad read answer.");
   write_retire_a: assert property (writeRetired |=> !s_axi_bvalid)
      else $error("Write response lingers.");
endmodule
bind abwc_area_bus_wait_control abwc_area_bus_wait_control_chk chk (.clk, .rst, .accReq,
   .accDone, .accResult, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// [tb/abwc_area_model.sv]
/*
 Requester model for the lookup port, standing for the bus cycle generator.
 Assumes go and area change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module abwc_area_model (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic go, // Ask this cycle.
   input wire logic [2:0] area, // Area to ask for.
   output logic accReq, // Request to the block.
   output logic [2:0] accArea // Area sent with it.
);
   // An idle area bus toggles, so a stale area is never taken for a fresh one.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accReq <= 1'h0;
         accArea <= 3'h0;
      end else begin
         accReq <= go;
         accArea <= go ? area : ~accArea;
      end
   end
endmodule
`default_nettype wire

// [tb/tb_area_bus_wait_control.sv]
/*
 Self-checking bench for the area bus and wait control block.
 Assumes every bus answer comes within 50 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_area_bus_wait_control;
   import abwc_pkg::*;
   logic clk = 1'h0, rst = 1'h1, go = 1'h0, accReq, accDone;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [31:0] s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] area = 3'h0, accArea;
   logic [7:0] bw, ast, wm, we;
   abwc_access_t accResult, got[8];
   int fail_count = 0, checked = 0;

   always #50 clk = ~clk;

   // Mode 2 straps make every area default to a 16-bit bus.
   abwc_area_bus_wait_control dut (.clk, .rst, .modePins(3'h2), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .accReq,
      .accArea, .accDone, .accResult);
   abwc_area_model model (.clk, .rst, .go, .area, .accReq, .accArea);
   ////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Every wait is bounded; a hang counts as a mismatch and ends the run.
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 50) begin
         fail_count++;
         wrap_up();
      end
   endtask
   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [29:0] i, input logic [7:0] v);
      int n = 0;
      @(posedge clk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         tick(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [29:0] i);
      int n = 0;
      @(posedge clk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         tick(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   // Expected cycle shape of one area from the shadow register values.
   function automatic abwc_access_t ex(int a);
      abwc_access_t e;
      e.width8 = bw[a];
      e.threeState = ast[a];
      e.waitMode = we[a] ? abwc_wait_mode_t'({1'h0, wm[3:2]}) : ABWC_WM_PIN0;
      e.waitStates = (we[a] && ast[a] && wm[3:2] == 2'h0) ? wm[1:0] : 2'h0;
      return e;
   endfunction
   // Registers are read back in map order; the wait-mode write drops its fixed nibble.
   task automatic regs(input logic doWrite);
      logic [7:0] v[4];
      v = '{bw, ast, wm, we};
      for (int i = 0; i < 4; i++) begin
         if (doWrite) wr(ABWC_IDX_BUS_WIDTH + 30'(i), v[i] & (i == 2 ? 8'h0F : 8'hFF));
         if (!doWrite) rd(ABWC_IDX_BUS_WIDTH + 30'(i));
         chk(32'(r), 32'(ABWC_RESP_OKAY));
         if (!doWrite) chk(d, {24'h0, v[i]});
      end
   endtask
   // Eight back-to-back lookups, one per area, answered in order.
   task automatic scan();
      int k = 0;
      @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         go <= (i < 8);
         area <= i[2:0];
         @(posedge clk);
         if (accDone && k < 8) begin
            got[k] = accResult;
            k++;
         end
      end
      chk(32'(k), 32'h8);
      for (int a = 0; a < 8; a++) begin
         chk(32'(got[a]), 32'(ex(a)));
      end
   endtask
   ////////////////////////////////////////////////////////
   initial begin
      bw = 8'h00;
      ast = 8'hFF;
      wm = 8'hF3;
      we = 8'hFF;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      regs(1'h0);
      scan();
      $display("test defaults done");
      // Mixed areas: some 8-bit, some two-state, the upper four without wait control.
      bw = 8'hA5;
      ast = 8'h3C;
      we = 8'h0F;
      for (int v = 0; v < 16; v++) begin
         wm = 8'hF0 | 8'(v);
         regs(1'h1);
         regs(1'h0);
         scan();
      end
      $display("test modes done");
      // An unmapped index is refused and leaves the map untouched.
      wr(30'hF0, 8'h55);
      chk(32'(r), 32'(ABWC_RESP_SLVERR));
      rd(30'hF0);
      chk(d, 32'h0);
      chk(32'(r), 32'(ABWC_RESP_SLVERR));
      regs(1'h0);
      $display("test unmapped done");
      wrap_up();
   end
endmodule
`default_nettype wire
